// ---- shared/nvm_guard_pkg.sv ----
package nvm_guard_pkg;
    // Core clock 20 MHz
    localparam int unsigned CLK_HZ             = 20000000;
    // Power-up timer, in milliseconds
    localparam int unsigned PWRT_MS            = 64;
    localparam int unsigned PWRT_CYCLES        = PWRT_MS * (CLK_HZ / 1000);
    // Typical array write time, in milliseconds
    localparam int unsigned WRITE_MS           = 2;
    localparam int unsigned WRITE_CYCLES       = WRITE_MS * (CLK_HZ / 1000);
    // Instruction cycles of write set-up after write_go
    localparam int unsigned SETUP_CYCLES       = 2;
    // Unlock key bytes
    localparam logic [7:0]  KEY_FIRST          = 8'h55;
    localparam logic [7:0]  KEY_SECOND         = 8'haa;
    // Protect fuse value meaning data is protected
    localparam logic        FUSE_PROTECTED     = 1'b0;
    localparam logic        LATCH_ONLY_ON      = 1'b1;
    // Reset values
    localparam logic        WRITE_PERMIT_RST   = 1'b0;
    localparam logic        WRITE_GO_RST       = 1'b0;
    localparam logic        DONE_FLAG_RST      = 1'b0;
    localparam int unsigned CNT_W              = 21;

    // Unlock sequence tracker
    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_GOT1 = 2'b01,
        KEY_GOT2 = 2'b11
    } key_state_type;

    // Write sequencer, Gray along idle-setup-stall-finish
    typedef enum logic [1:0] {
        WR_IDLE   = 2'b00,
        WR_SETUP  = 2'b01,
        WR_STALL  = 2'b11,
        WR_FINISH = 2'b10
    } wr_state_type;
endpackage

// ---- shared/nvm_timer_if.sv ----
`timescale 1ns/1ps
interface nvm_timer_if;
    logic                            load;
    logic [nvm_guard_pkg::CNT_W-1:0] count;
    logic                            expired;

    modport owner (output load, output count, input expired);
    modport timer (input load, input count, output expired);
endinterface

// ---- sim/nvm_cpu_model.sv ----
`timescale 1ns/1ps
// Idle key data rests at the first key byte, with key_wr_o held low
module nvm_cpu_model (input wire logic ref_clk_i, output logic key_wr_o,
    output logic [7:0] key_data_o);
    initial {key_wr_o, key_data_o} = 9'h055;
    task unlock();
        {key_wr_o, key_data_o} = {1'b1, nvm_guard_pkg::KEY_FIRST};
        @(negedge ref_clk_i) key_data_o = nvm_guard_pkg::KEY_SECOND;
        @(negedge ref_clk_i) {key_wr_o, key_data_o} = 9'h055;
    endtask
endmodule

// ---- sim/nvm_guard_chk.sv ----
`timescale 1ns/1ps
module nvm_guard_chk (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic permit_clr_i,
    input wire logic done_clr_i,
    input wire logic ext_req_i,
    input wire logic data_protect_fuse_i,
    input wire logic write_permit_o,
    input wire logic write_go_o,
    input wire logic nvm_done_flag_o,
    input wire logic pwrt_busy_o,
    input wire logic core_stall_o,
    input wire logic latch_load_o,
    input wire logic ext_grant_o,
    input wire logic sleep_allow_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Write launch and the set-up window that follows it
    sequence s_go_rise;
        $rose(write_go_o);
    endsequence
    sequence s_setup;
        !core_stall_o [*2];
    endsequence
    property p_setup; s_go_rise |-> s_setup; endproperty
    a_setup: assert property (p_setup) else $error("stall in set-up");
    property p_stall; core_stall_o |-> write_go_o; endproperty
    a_stall: assert property (p_stall) else $error("stall without go");
    property p_latch; latch_load_o |-> !core_stall_o; endproperty
    a_latch: assert property (p_latch) else $error("latch load stalled");
    property p_permit; write_permit_o && !permit_clr_i |=> write_permit_o; endproperty
    a_permit: assert property (p_permit) else $error("permit dropped");
    property p_done; nvm_done_flag_o && !done_clr_i |=> nvm_done_flag_o; endproperty
    a_done: assert property (p_done) else $error("done flag dropped");
    property p_ext;
        ext_grant_o |-> $past(ext_req_i, 2) && ($past(data_protect_fuse_i, 2) != 1'b0);
    endproperty
    a_ext: assert property (p_ext) else $error("grant while protected");
    property p_go; $rose(write_go_o) |-> $past(write_permit_o); endproperty
    a_go: assert property (p_go) else $error("go w/o permit");
    property p_pw; pwrt_busy_o |-> !write_go_o; endproperty
    a_pw: assert property (p_pw) else $error("go in power-up");
    property p_sl; core_stall_o |-> !sleep_allow_o; endproperty
    a_sl: assert property (p_sl) else $error("sleep in stall");
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 0, sys_rst_i = 1, permit_set_i = 0, permit_clr_i = 0, key_wr_i;
    logic write_go_set_i = 0, latch_only_load_i = 0, done_clr_i = 0, sleep_req_i = 0;
    logic data_protect_fuse_i = 0, ext_req_i = 0, write_permit_o, write_go_o;
    logic nvm_done_flag_o, pwrt_busy_o, core_stall_o, array_write_o, latch_load_o;
    logic ext_grant_o, sleep_allow_o, reject_o;
    logic [7:0] key_data_i;
    int n_fail = 0, comparisons = 0, seed = 19322;
    nvm_write_guard nvm_write_guard_i (.*);
    nvm_cpu_model cpu_i (.ref_clk_i, .key_wr_o(key_wr_i), .key_data_o(key_data_i));
    always #25 ref_clk_i = ~ref_clk_i;
    task check(input logic seen, exp);
        comparisons++;
        if (seen !== exp) n_fail++;
        if (seen !== exp) $display("MISMATCH %0t flag", $time);
    endtask
    // External access allowed only with the fuse left unprogrammed
    function automatic logic exp_grant(input logic req, input logic fuse);
        return req && (fuse != nvm_guard_pkg::FUSE_PROTECTED);
    endfunction
    task summarize;
        $display("%0d checks %0d fails", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog far beyond the hundred or so cycles used
    initial #100000 begin
        n_fail++;
        summarize;
    end
    // Power-up timer outlasts the run, so every attempt here must be refused
    initial begin
        repeat (20) @(negedge ref_clk_i);
        sys_rst_i = 0;
        check(write_permit_o, 0);
        check(pwrt_busy_o, 1);
        permit_set_i = 1;
        @(negedge ref_clk_i) permit_set_i = 0;
        cpu_i.unlock();
        write_go_set_i = 1;
        @(negedge ref_clk_i) write_go_set_i = 0;
        check(reject_o, 1);
        repeat (2) @(negedge ref_clk_i);
        check(write_go_o | nvm_done_flag_o, 0);
        check(core_stall_o | array_write_o | latch_load_o, 0);
        check(write_permit_o, 1);
        $display("guard done");
        // Permit cleared: go must stay refused
        permit_clr_i = 1;
        @(negedge ref_clk_i) permit_clr_i = 0;
        cpu_i.unlock();
        write_go_set_i = 1;
        @(negedge ref_clk_i) write_go_set_i = 0;
        check(reject_o, 1);
        check(write_go_o, 0);
        // Reset in mid-run clears the permit and restarts the hold-off
        permit_set_i = 1;
        @(negedge ref_clk_i) permit_set_i = 0;
        sys_rst_i = 1;
        repeat (3) @(negedge ref_clk_i);
        sys_rst_i = 0;
        @(negedge ref_clk_i);
        check(write_permit_o, 0);
        check(pwrt_busy_o, 1);
        $display("reset done");
        // Corner case: protected fuse with a request pending
        {data_protect_fuse_i, ext_req_i} = 2'h1;
        repeat (2) @(negedge ref_clk_i);
        check(ext_grant_o, exp_grant(ext_req_i, data_protect_fuse_i));
        repeat (30) begin
            {data_protect_fuse_i, ext_req_i, sleep_req_i} = 3'($random(seed));
            repeat (2) @(negedge ref_clk_i);
            check(ext_grant_o, exp_grant(ext_req_i, data_protect_fuse_i));
            check(sleep_allow_o, sleep_req_i);
        end
        $display("fuse done");
        summarize;
    end
endmodule
bind nvm_write_guard nvm_guard_chk nvm_guard_chk_i (.*);

// ---- src/nvm_down_timer.sv ----
`timescale 1ns/1ps
// Loadable down counter shared by power-up and write timing
module nvm_down_timer (
    input  wire logic  ref_clk_i,
    input  wire logic  sys_rst_i,
    input  wire logic  start_i,
    nvm_timer_if.timer tmr
);
    logic [nvm_guard_pkg::CNT_W-1:0] cnt_q;
    logic [nvm_guard_pkg::CNT_W-1:0] cnt_d;

    // Reload wins over counting
    always_comb begin
        cnt_d = cnt_q;
        if (tmr.load) begin
            cnt_d = tmr.count;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - nvm_guard_pkg::CNT_W'(1);
        end
    end

    // Starts at zero; the owner holds off at power-up by loading it
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tmr.expired = (cnt_q == '0) && !tmr.load && !start_i;
endmodule

// ---- src/nvm_write_guard.sv ----
`timescale 1ns/1ps
module nvm_write_guard (
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       permit_set_i,
    input  wire logic       permit_clr_i,
    input  wire logic       key_wr_i,
    input  wire logic [7:0] key_data_i,
    input  wire logic       write_go_set_i,
    input  wire logic       latch_only_load_i,
    input  wire logic       done_clr_i,
    input  wire logic       data_protect_fuse_i,
    input  wire logic       ext_req_i,
    input  wire logic       sleep_req_i,
    output logic            write_permit_o,
    output logic            write_go_o,
    output logic            nvm_done_flag_o,
    output logic            pwrt_busy_o,
    output logic            core_stall_o,
    output logic            array_write_o,
    output logic            latch_load_o,
    output logic            ext_grant_o,
    output logic            sleep_allow_o,
    output logic            reject_o
);
    // Timer carrier shared by the power-up hold-off and the write timing
    nvm_timer_if tmr ();

    // Pin-side inputs, two flops each before any logic reads them
    logic fuse_meta_q;
    logic fuse_sync_q;
    logic ext_meta_q;
    logic ext_sync_q;

    // Power-up hold-off
    logic pwrt_load_q;
    logic pwrt_load_d;
    logic pwrt_busy_q;
    logic pwrt_busy_d;

    // Software-owned control and status bits
    logic write_permit_q;
    logic write_permit_d;
    logic done_flag_q;
    logic done_flag_d;

    // Unlock tracker
    nvm_guard_pkg::key_state_type key_q;
    nvm_guard_pkg::key_state_type key_d;

    // Write sequencer
    nvm_guard_pkg::wr_state_type wr_q;
    nvm_guard_pkg::wr_state_type wr_d;
    logic                        write_go_q;
    logic                        write_go_d;
    logic                        latch_only_q;
    logic                        latch_only_d;
    logic [1:0]                  setup_cnt_q;
    logic [1:0]                  setup_cnt_d;
    logic                        latch_load_q;
    logic                        latch_load_d;
    logic                        reject_q;
    logic                        reject_d;

    // Request decode
    logic                        go_accept;
    logic                        timer_load_write;

    // Synchronisers for the fuse and the external access request
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // Fuse reads as protected until sampled, the safe side
            fuse_meta_q <= nvm_guard_pkg::FUSE_PROTECTED;
            fuse_sync_q <= nvm_guard_pkg::FUSE_PROTECTED;
            ext_meta_q  <= 1'b0;
            ext_sync_q  <= 1'b0;
        end else begin
            fuse_meta_q <= data_protect_fuse_i;
            fuse_sync_q <= fuse_meta_q;
            ext_meta_q  <= ext_req_i;
            ext_sync_q  <= ext_meta_q;
        end
    end

    // Power-up hold-off next state
    // Load pulse lasts one cycle; busy drops only once the count runs out
    always_comb begin
        pwrt_load_d = 1'b0;
        pwrt_busy_d = pwrt_busy_q;
        if (pwrt_busy_q && !pwrt_load_q && tmr.expired) begin
            pwrt_busy_d = 1'b0;
        end
    end

    // Power-up hold-off registers, busy from reset on
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pwrt_load_q <= 1'b1;
            pwrt_busy_q <= 1'b1;
        end else begin
            pwrt_load_q <= pwrt_load_d;
            pwrt_busy_q <= pwrt_busy_d;
        end
    end

    // One timer serves both phases; writes cannot start while power-up runs
    assign tmr.load  = pwrt_load_q || timer_load_write;
    assign tmr.count = pwrt_load_q ? nvm_guard_pkg::CNT_W'(nvm_guard_pkg::PWRT_CYCLES)
                                   : nvm_guard_pkg::CNT_W'(nvm_guard_pkg::WRITE_CYCLES);

    nvm_down_timer nvm_down_timer_i (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (pwrt_load_q),
        .tmr       (tmr)
    );

    // Control bits next state
    always_comb begin
        write_permit_d = write_permit_q;
        // Only software moves the permit bit, never a finished write
        if (permit_clr_i) begin
            write_permit_d = 1'b0;
        end
        if (permit_set_i) begin
            write_permit_d = 1'b1;
        end
        done_flag_d = done_flag_q;
        if (done_clr_i) begin
            done_flag_d = 1'b0;
        end
        // Set wins over a clear in the same cycle, so no completion is lost
        if ((wr_q == nvm_guard_pkg::WR_FINISH) && !latch_only_q) begin
            done_flag_d = 1'b1;
        end
    end

    // Control bits registers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            write_permit_q <= nvm_guard_pkg::WRITE_PERMIT_RST;
            done_flag_q    <= nvm_guard_pkg::DONE_FLAG_RST;
        end else begin
            write_permit_q <= write_permit_d;
            done_flag_q    <= done_flag_d;
        end
    end

    // Unlock tracker next state
    // Any go attempt spends the unlock, so every byte needs a fresh sequence
    always_comb begin
        key_d = key_q;
        if (write_go_set_i) begin
            key_d = nvm_guard_pkg::KEY_IDLE;
        end else if (key_wr_i) begin
            unique case (key_q)
                nvm_guard_pkg::KEY_GOT1: begin
                    if (key_data_i == nvm_guard_pkg::KEY_SECOND) begin
                        key_d = nvm_guard_pkg::KEY_GOT2;
                    end else if (key_data_i == nvm_guard_pkg::KEY_FIRST) begin
                        key_d = nvm_guard_pkg::KEY_GOT1;
                    end else begin
                        key_d = nvm_guard_pkg::KEY_IDLE;
                    end
                end
                default: begin
                    // Idle, armed, or an illegal code: restart on a first key
                    if (key_data_i == nvm_guard_pkg::KEY_FIRST) begin
                        key_d = nvm_guard_pkg::KEY_GOT1;
                    end else begin
                        key_d = nvm_guard_pkg::KEY_IDLE;
                    end
                end
            endcase
        end
    end

    // Unlock tracker register
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            key_q <= nvm_guard_pkg::KEY_IDLE;
        end else begin
            key_q <= key_d;
        end
    end

    // A go request counts only when every guard agrees
    assign go_accept = write_go_set_i
                       && (key_q == nvm_guard_pkg::KEY_GOT2)
                       && write_permit_q
                       && !pwrt_busy_q
                       && (wr_q == nvm_guard_pkg::WR_IDLE)
                       && !write_go_q;

    // Write sequencer next state
    always_comb begin
        wr_d             = wr_q;
        write_go_d       = write_go_q;
        latch_only_d     = latch_only_q;
        setup_cnt_d      = setup_cnt_q;
        latch_load_d     = 1'b0;
        timer_load_write = 1'b0;
        // Refused attempts leave go, array and flag alone
        reject_d         = write_go_set_i && !go_accept;
        unique case (wr_q)
            nvm_guard_pkg::WR_IDLE: begin
                if (go_accept) begin
                    wr_d         = nvm_guard_pkg::WR_SETUP;
                    write_go_d   = 1'b1;
                    latch_only_d = (latch_only_load_i == nvm_guard_pkg::LATCH_ONLY_ON);
                    setup_cnt_d  = 2'(nvm_guard_pkg::SETUP_CYCLES - 1);
                end
            end
            nvm_guard_pkg::WR_SETUP: begin
                if (setup_cnt_q != 2'h0) begin
                    setup_cnt_d = setup_cnt_q - 2'h1;
                end else if (latch_only_q) begin
                    // Latch load only: no array cycle, core keeps running
                    latch_load_d = 1'b1;
                    wr_d         = nvm_guard_pkg::WR_FINISH;
                end else begin
                    timer_load_write = 1'b1;
                    wr_d             = nvm_guard_pkg::WR_STALL;
                end
            end
            nvm_guard_pkg::WR_STALL: begin
                // Stall ends with the count; the core resumes after its nops
                if (tmr.expired) begin
                    wr_d = nvm_guard_pkg::WR_FINISH;
                end
            end
            nvm_guard_pkg::WR_FINISH: begin
                write_go_d = 1'b0;
                wr_d       = nvm_guard_pkg::WR_IDLE;
            end
        endcase
    end

    // Write sequencer registers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_q         <= nvm_guard_pkg::WR_IDLE;
            write_go_q   <= nvm_guard_pkg::WRITE_GO_RST;
            latch_only_q <= 1'b0;
            setup_cnt_q  <= 2'h0;
            latch_load_q <= 1'b0;
            reject_q     <= 1'b0;
        end else begin
            wr_q         <= wr_d;
            write_go_q   <= write_go_d;
            latch_only_q <= latch_only_d;
            setup_cnt_q  <= setup_cnt_d;
            latch_load_q <= latch_load_d;
            reject_q     <= reject_d;
        end
    end

    // Outputs
    assign write_permit_o  = write_permit_q;
    assign write_go_o      = write_go_q;
    assign nvm_done_flag_o = done_flag_q;
    assign pwrt_busy_o     = pwrt_busy_q;
    assign core_stall_o    = (wr_q == nvm_guard_pkg::WR_STALL);
    assign array_write_o   = (wr_q == nvm_guard_pkg::WR_STALL);
    assign latch_load_o    = latch_load_q;
    assign reject_o        = reject_q;
    // Protected data is reachable by the core only
    assign ext_grant_o     = ext_sync_q && (fuse_sync_q != nvm_guard_pkg::FUSE_PROTECTED);
    // Stall is not sleep: clocks keep running
    assign sleep_allow_o   = sleep_req_i && (wr_q != nvm_guard_pkg::WR_STALL);
endmodule
